//--- hw/pllsd_pkg.sv
// Shared constants, types and helpers of the synthesizer load block
package pllsd_pkg;
    // Serial word layout, bit 0 is the last bit shifted in
    localparam int SHIFT_W = 19;
    localparam int SEL_POS = 0;
    localparam int SWALLOW_W = 7;
    localparam int SWALLOW_LSB = 1;
    localparam int MAIN_W = 11;
    localparam int MAIN_LSB = 8;
    localparam int REF_W = 14;
    localparam int REF_LSB = 1;
    // Reset values of the latched divide factors
    localparam logic [6:0] SWALLOW_RST = 7'h00;
    localparam logic [10:0] MAIN_RST = 11'h005;
    localparam logic [13:0] REF_RST = 14'h0008;
    // Register offsets
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MASK = 8'h04;
    localparam logic [7:0] ADDR_SWALLOW = 8'h08;
    localparam logic [7:0] ADDR_MAIN = 8'h0C;
    localparam logic [7:0] ADDR_REF = 8'h10;
    localparam logic [7:0] ADDR_STATE = 8'h14;
    // Event bits of status and mask
    localparam int EV_W = 4;
    localparam int EV_MAIN = 0;
    localparam int EV_REF = 1;
    localparam int EV_UNLOCK = 2;
    localparam int EV_AWAKE = 3;
    localparam logic [3:0] MASK_RST = 4'h0;
    // Power sequencing, Gray along the wake-up path
    typedef enum logic [1:0] {
        PWR_DOWN = 2'b00,
        MAIN_RUN = 2'b01,
        REF_RUN = 2'b11,
        NORMAL = 2'b10
    } pllsd_pwr_t;

    // Rising edge between two samples
    function automatic logic rise(input logic prev, input logic cur);
        rise = cur & ~prev;
    endfunction
endpackage

//--- hw/pllsd_word_if.sv
// Carrier of shifted divide words from the serial input to the core
`timescale 1ns/100ps
interface pllsd_word_if;
    logic load_main;
    logic load_ref;
    logic [pllsd_pkg::SWALLOW_W-1:0] swallow;
    logic [pllsd_pkg::MAIN_W-1:0] main_n;
    logic [pllsd_pkg::REF_W-1:0] ref_r;
    modport src (output load_main, load_ref, swallow, main_n, ref_r);
    modport dst (input load_main, load_ref, swallow, main_n, ref_r);
endinterface

//--- hw/pllsd_serial_in.sv
// Serial shift register with select bit and load strobe decode
`timescale 1ns/100ps
module pllsd_serial_in (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    // Serial pins
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic load_strobe,
    // Word towards the core
    pllsd_word_if.src word
);
    logic [2:0] meta;
    logic [2:0] sync;
    logic sclk_prev;
    logic [pllsd_pkg::SHIFT_W-1:0] shreg;
    logic [2:0] next_meta;
    logic [2:0] next_sync;
    logic next_sclk_prev;
    logic [pllsd_pkg::SHIFT_W-1:0] next_shreg;

    // Two-stage sync, then shift on each serial clock rise
    always_comb begin
        next_meta = {serial_clk, serial_data, load_strobe};
        next_sync = meta;
        next_sclk_prev = sync[2];
        next_shreg = shreg;
        if (pllsd_pkg::rise(sclk_prev, sync[2])) begin
            next_shreg =
                {shreg[pllsd_pkg::SHIFT_W-2:0], sync[1]};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 3'h0;
            sync <= 3'h0;
            sclk_prev <= 1'b0;
            shreg <= '0;
        end else if (en) begin
            meta <= next_meta;
            sync <= next_sync;
            sclk_prev <= next_sclk_prev;
            shreg <= next_shreg;
        end
    end

    // Last bit in picks the destination while the strobe is high
    assign word.load_main =
        sync[0] & ~shreg[pllsd_pkg::SEL_POS];
    assign word.load_ref = sync[0] & shreg[pllsd_pkg::SEL_POS];
    assign word.swallow =
        shreg[pllsd_pkg::SWALLOW_LSB +: pllsd_pkg::SWALLOW_W];
    assign word.main_n =
        shreg[pllsd_pkg::MAIN_LSB +: pllsd_pkg::MAIN_W];
    assign word.ref_r = shreg[pllsd_pkg::REF_LSB +: pllsd_pkg::REF_W];
endmodule

//--- hw/pllsd_prog_div.sv
// Programmable down counter giving one pulse per preset input edges
`timescale 1ns/100ps
module pllsd_prog_div #(
    parameter int W = 14
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    // Control and count input
    input wire logic run,
    input wire logic tick,
    input wire logic [W-1:0] preset,
    // Divided output
    output logic pulse
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic next_pulse;

    // Zero means freshly started: first edge loads the preset
    always_comb begin
        next_cnt = cnt;
        next_pulse = 1'b0;
        if (!run) begin
            next_cnt = '0;
        end else if (tick) begin
            if (cnt <= W'(1)) begin
                next_cnt = preset;
                next_pulse = (cnt == W'(1));
            end else begin
                next_cnt = cnt - W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            pulse <= 1'b0;
        end else if (en) begin
            cnt <= next_cnt;
            pulse <= next_pulse;
        end
    end
endmodule

//--- hw/pllsd_top.sv
// Serial-programmed divider core with power-down sequencing
`timescale 1ns/100ps
// Function
// - each serial clock rise shifts one data bit into the shifter.
// - main word bits 1-7 are swallow, bits 8-18 main count.
// - swallow value is plain binary 0 to 127, bit 1 least.
// - lock detect high while divided signals differ, low when locked.
// - power select low means power-down, dividers stop.
// - loop control output held low during power-down.
// - on wake main divider runs first, reference after its pulse.
// - with first divided reference, loop control goes high in the same cycle.
// - power select low again stops and resets the dividers.
// - last serial bit selects reference (high) or main (low).
// - while load strobe high, shifted word goes to chosen divider.
module pllsd_top #(
    parameter int SWALLOW_W = 7,
    parameter int MAIN_W = 11,
    parameter int REF_W = 14
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    // Serial programming pins
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic load_strobe,
    // Power and frequency inputs
    input wire logic power_select,
    input wire logic osc_in,
    input wire logic vco_in,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // Synthesizer outputs
    output logic divided_reference,
    output logic divided_vco,
    output logic lock_detect_out,
    output logic loop_control_out,
    output logic modulus_ctl,
    output logic irq
);
    pllsd_word_if word ();

    logic [2:0] meta;
    logic [2:0] sync;
    logic osc_prev;
    logic vco_prev;
    logic [2:0] next_meta;
    logic [2:0] next_sync;
    logic osc_tick;
    logic vco_tick;
    logic ps;

    pllsd_pkg::pllsd_pwr_t state;
    pllsd_pkg::pllsd_pwr_t next_state;
    logic next_loop;

    logic [SWALLOW_W-1:0] swallow_val;
    logic [MAIN_W-1:0] main_val;
    logic [REF_W-1:0] ref_val;
    logic [SWALLOW_W-1:0] next_swallow_val;
    logic [MAIN_W-1:0] next_main_val;
    logic [REF_W-1:0] next_ref_val;

    logic [SWALLOW_W-1:0] swallow_left;
    logic [SWALLOW_W-1:0] next_swallow_left;
    logic next_modulus;
    logic main_run;
    logic ref_run;
    logic main_pulse;
    logic ref_pulse;

    logic ahead;
    logic next_ahead;

    logic [pllsd_pkg::EV_W-1:0] status;
    logic [pllsd_pkg::EV_W-1:0] mask;
    logic [pllsd_pkg::EV_W-1:0] events;
    logic [pllsd_pkg::EV_W-1:0] next_status;
    logic [pllsd_pkg::EV_W-1:0] next_mask;
    logic [31:0] next_rdata;
    logic next_irq;

    pllsd_serial_in u_serial (
        .clk(clk),
        .rst_n(rst_n),
        .en(en),
        .serial_clk(serial_clk),
        .serial_data(serial_data),
        .load_strobe(load_strobe),
        .word(word)
    );

    // Pins from outside the domain: two flops, then edge find
    always_comb begin
        next_meta = {power_select, osc_in, vco_in};
        next_sync = meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 3'h0;
            sync <= 3'h0;
            osc_prev <= 1'b0;
            vco_prev <= 1'b0;
        end else if (en) begin
            meta <= next_meta;
            sync <= next_sync;
            osc_prev <= sync[1];
            vco_prev <= sync[0];
        end
    end

    assign ps = sync[2];
    assign osc_tick = pllsd_pkg::rise(osc_prev, sync[1]);
    assign vco_tick = pllsd_pkg::rise(vco_prev, sync[0]);

    // Latch the shifted word into the selected divider
    always_comb begin
        next_swallow_val = swallow_val;
        next_main_val = main_val;
        next_ref_val = ref_val;
        if (word.load_main) begin
            next_swallow_val = word.swallow;
            next_main_val = word.main_n;
        end
        if (word.load_ref) begin
            next_ref_val = word.ref_r;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            swallow_val <= pllsd_pkg::SWALLOW_RST;
            main_val <= pllsd_pkg::MAIN_RST;
            ref_val <= pllsd_pkg::REF_RST;
        end else if (en) begin
            swallow_val <= next_swallow_val;
            main_val <= next_main_val;
            ref_val <= next_ref_val;
        end
    end

    // Wake-up order: main divider, then reference, then loop control
    always_comb begin
        next_state = state;
        case (state)
            pllsd_pkg::PWR_DOWN: begin
                if (ps) begin
                    next_state = pllsd_pkg::MAIN_RUN;
                end
            end
            pllsd_pkg::MAIN_RUN: begin
                if (!ps) begin
                    next_state = pllsd_pkg::PWR_DOWN;
                end else if (main_pulse) begin
                    next_state = pllsd_pkg::REF_RUN;
                end
            end
            pllsd_pkg::REF_RUN: begin
                if (!ps) begin
                    next_state = pllsd_pkg::PWR_DOWN;
                end else if (ref_pulse) begin
                    next_state = pllsd_pkg::NORMAL;
                end
            end
            pllsd_pkg::NORMAL: begin
                if (!ps) begin
                    next_state = pllsd_pkg::PWR_DOWN;
                end
            end
            default: begin
                next_state = pllsd_pkg::PWR_DOWN;
            end
        endcase
        // Low in power-down and all through wake-up
        next_loop = (next_state == pllsd_pkg::NORMAL);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= pllsd_pkg::PWR_DOWN;
            loop_control_out <= 1'b0;
        end else if (en) begin
            state <= next_state;
            loop_control_out <= next_loop;
        end
    end

    // Dividers idle and cleared whenever power select is low
    assign main_run = (state != pllsd_pkg::PWR_DOWN);
    assign ref_run = (state == pllsd_pkg::REF_RUN) ||
                     (state == pllsd_pkg::NORMAL);

    pllsd_prog_div #(.W(MAIN_W)) u_main_div (
        .clk(clk),
        .rst_n(rst_n),
        .en(en),
        .run(main_run),
        .tick(vco_tick),
        .preset(main_val),
        .pulse(main_pulse)
    );

    pllsd_prog_div #(.W(REF_W)) u_ref_div (
        .clk(clk),
        .rst_n(rst_n),
        .en(en),
        .run(ref_run),
        .tick(osc_tick),
        .preset(ref_val),
        .pulse(ref_pulse)
    );

    // Swallow count restarts with each main cycle; a main count
    // below the swallow count never lets it finish
    always_comb begin
        next_swallow_left = swallow_left;
        if (!main_run) begin
            next_swallow_left = swallow_val;
        end else if (main_pulse) begin
            next_swallow_left = swallow_val;
        end else if (vco_tick && swallow_left != '0) begin
            next_swallow_left = swallow_left - SWALLOW_W'(1);
        end
        // High asks the smaller modulus
        next_modulus = main_run &&
                       (next_swallow_left == '0);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            swallow_left <= '0;
            modulus_ctl <= 1'b0;
        end else if (en) begin
            swallow_left <= next_swallow_left;
            modulus_ctl <= next_modulus;
        end
    end

    // Phase compare: each lone pulse of either divider flips the gap open or shut
    always_comb begin
        next_ahead = ahead;
        if (!main_run) begin
            next_ahead = 1'b0;
        end else if (main_pulse ^ ref_pulse) begin
            next_ahead = ~ahead;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ahead <= 1'b0;
            lock_detect_out <= 1'b0;
            divided_vco <= 1'b0;
            divided_reference <= 1'b0;
        end else if (en) begin
            ahead <= next_ahead;
            lock_detect_out <= next_ahead;
            divided_vco <= main_pulse;
            divided_reference <= ref_pulse;
        end
    end

    // Events; a set in the clearing read's cycle still lands
    always_comb begin
        events = '0;
        events[pllsd_pkg::EV_MAIN] = word.load_main;
        events[pllsd_pkg::EV_REF] = word.load_ref;
        events[pllsd_pkg::EV_UNLOCK] = next_ahead & ~ahead;
        events[pllsd_pkg::EV_AWAKE] = next_loop & ~loop_control_out;
        next_status = status | events;
        if (rd && addr == pllsd_pkg::ADDR_STATUS) begin
            next_status = events;
        end
        next_mask = mask;
        if (wr && addr == pllsd_pkg::ADDR_MASK) begin
            next_mask = wdata[pllsd_pkg::EV_W-1:0];
        end
        next_irq = |(next_status & next_mask);
    end

    // Read data stands only in the cycle after the strobe
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (rd) begin
            case (addr)
                pllsd_pkg::ADDR_STATUS: next_rdata = 32'(status);
                pllsd_pkg::ADDR_MASK: next_rdata = 32'(mask);
                pllsd_pkg::ADDR_SWALLOW: next_rdata = 32'(swallow_val);
                pllsd_pkg::ADDR_MAIN: next_rdata = 32'(main_val);
                pllsd_pkg::ADDR_REF: next_rdata = 32'(ref_val);
                pllsd_pkg::ADDR_STATE: begin
                    next_rdata = 32'({ahead, loop_control_out, state});
                end
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status <= '0;
            mask <= pllsd_pkg::MASK_RST;
            irq <= 1'b0;
            rdata <= 32'h0000_0000;
        end else if (en) begin
            status <= next_status;
            mask <= next_mask;
            irq <= next_irq;
            rdata <= next_rdata;
        end
    end
endmodule

//--- verif/pllsd_top_props.sv
// Concurrent checks on the synthesizer load block ports
`timescale 1ns/100ps
module pllsd_top_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Watched pins
    input wire logic power_select,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic divided_reference,
    input wire logic divided_vco,
    input wire logic lock_detect_out,
    input wire logic loop_control_out
);
    logic [2:0] lo_cnt;
    logic [2:0] next_lo_cnt;
    logic vco_seen;
    logic next_vco_seen;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Age of power-down, saturating so the pin sync latency is covered
    always_comb begin
        next_lo_cnt = power_select ? 3'h0 : lo_cnt + {2'h0, lo_cnt != 3'h7};
        next_vco_seen = divided_vco | (vco_seen & (lo_cnt != 3'h7));
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lo_cnt <= 3'h0;
            vco_seen <= 1'b0;
        end else begin
            lo_cnt <= next_lo_cnt;
            vco_seen <= next_vco_seen;
        end
    end

    // Entry into normal operation
    sequence s_normal_entry;
        !loop_control_out ##1 loop_control_out;
    endsequence

    AST_PWRDN_LC: assert property (
        !power_select [*6] |-> !loop_control_out)
        else $error("loop control high in power-down");
    AST_PWRDN_DIV: assert property (
        lo_cnt == 3'h7 |-> !divided_vco && !divided_reference)
        else $error("divider pulse in power-down");
    AST_NORMAL_ENTRY: assert property (
        s_normal_entry |-> divided_reference)
        else $error("loop control rose without reference pulse");
    AST_REF_AFTER_VCO: assert property (
        divided_reference |-> vco_seen || divided_vco)
        else $error("reference pulse before vco pulse");
    AST_WAKE_QUIET: assert property (
        $rose(power_select) && !loop_control_out
        |=> !loop_control_out [*8])
        else $error("loop control high too soon after wake");
    AST_LOCK_RISE: assert property (
        $rose(lock_detect_out) |-> (divided_reference != divided_vco)
        || ($past(divided_reference) != $past(divided_vco)))
        else $error("lock detect rose without lone pulse");
    AST_RDATA_IDLE: assert property (
        !rd |=> rdata == 32'h0000_0000)
        else $error("read data not zero outside answer");
    AST_VCO_PULSE: assert property (
        divided_vco |=> !divided_vco [*4])
        else $error("vco pulses too close");
    AST_REF_PULSE: assert property (
        divided_reference |=> !divided_reference [*7])
        else $error("reference pulses too close");
endmodule

bind pllsd_top pllsd_top_props pllsd_top_props_inst (.clk(clk),
    .rst_n(rst_n), .power_select(power_select), .rd(rd), .rdata(rdata),
    .divided_reference(divided_reference), .divided_vco(divided_vco),
    .lock_detect_out(lock_detect_out), .loop_control_out(loop_control_out));

//--- verif/pllsd_host.sv
// Host model shifting divide words into the synthesizer pins
`timescale 1ns/100ps
module pllsd_host (
    // Serial programming pins
    output logic serial_clk,
    output logic serial_data,
    output logic load_strobe
);
    // Clock idles low between frames
    initial begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        load_strobe = 1'b0;
    end

    // MSB first, select bit last, 125 ns a bit; slow delays the strobe
    task automatic send(input logic [18:0] w, input int n, input int slow);
        for (int i = n - 1; i >= 0; i--) begin
            serial_data = w[i];
            #62.5;
            serial_clk = 1'b1;
            #62.5;
            serial_clk = 1'b0;
        end
        // Data no longer held once the frame is over
        serial_data = ~w[0];
        #(40 + slow);
        load_strobe = 1'b1;
        #40;
        load_strobe = 1'b0;
        #40;
    endtask
endmodule

//--- verif/tb.sv
// Self-checking bench of the synthesizer load block
`timescale 1ns/100ps
module tb;
    logic clk, rst_n, en, power_select, osc_in, vco_in, wr, rd;
    logic serial_clk, serial_data, load_strobe, modulus_ctl, irq;
    logic divided_reference, divided_vco, lock_detect_out, loop_control_out;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    int num_errors = 0;
    int n_checks = 0;
    localparam logic [31:0] ZERO = 32'h0000_0000;
    localparam logic [31:0] ONE = 32'h0000_0001;

    // Bus clock, then vco and reference inputs kept off its edges
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        vco_in = 1'b0;
        #1;
        forever #20 vco_in = ~vco_in;
    end
    initial begin
        osc_in = 1'b0;
        #1;
        forever #24 osc_in = ~osc_in;
    end

    pllsd_top pllsd_top_inst (.clk, .rst_n, .en, .serial_clk, .serial_data,
        .load_strobe, .power_select, .osc_in, .vco_in, .addr, .wdata, .wr,
        .rd, .rdata, .divided_reference, .divided_vco, .lock_detect_out,
        .loop_control_out, .modulus_ctl, .irq);
    pllsd_host pllsd_host_inst (.serial_clk, .serial_data, .load_strobe);

    // Expected serial words, select bit last
    function automatic logic [18:0] main_word(logic [6:0] a, logic [10:0] n);
        return {n, a, 1'b0};
    endfunction
    function automatic logic [18:0] ref_word(logic [3:0] j, logic [13:0] r);
        return {j, r, 1'b1};
    endfunction

    // Compare and bus helpers
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic chk_rd(logic [7:0] a, logic [31:0] exp);
        logic [31:0] d;
        reg_rd(a, d);
        chk(d, exp);
    endtask

    // Raise power at a fixed vco phase and log pulse timing
    task automatic wake(output int t1, tr, tl, per, ml, lk);
        int nv, t2;
        nv = 0;
        t1 = -1;
        tr = -1;
        tl = -1;
        t2 = 0;
        per = 0;
        ml = 0;
        lk = 0;
        @(posedge vco_in);
        @(posedge clk);
        power_select <= 1'b1;
        for (int k = 0; k < 600; k++) begin
            @(posedge clk);
            #1;
            if (divided_vco === 1'b1) begin
                nv++;
                if (nv == 1) t1 = k;
                if (nv == 2) t2 = k;
                if (nv == 3) per = k - t2;
            end
            if (nv == 2 && modulus_ctl === 1'b0) ml++;
            if (divided_reference === 1'b1 && tr < 0) tr = k;
            if (loop_control_out === 1'b1 && tl < 0) tl = k;
            if (lock_detect_out === 1'b1) lk = 1;
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        logic [31:0] d;
        logic [6:0] a;
        logic [10:0] n;
        logic [13:0] r;
        int t1, tr, tl, per, ml, lk, t1b, x;
        rst_n = 1'b0;
        en = 1'b1;
        power_select = 1'b0;
        addr = 8'h00;
        wdata = ZERO;
        wr = 1'b0;
        rd = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        void'($urandom(32'h0965));
        chk_rd(pllsd_pkg::ADDR_SWALLOW, 32'(pllsd_pkg::SWALLOW_RST));
        chk_rd(pllsd_pkg::ADDR_REF, 32'(pllsd_pkg::REF_RST));
        chk_rd(pllsd_pkg::ADDR_MASK, 32'(pllsd_pkg::MASK_RST));
        reg_wr(pllsd_pkg::ADDR_MAIN, 32'h0000_07FF);
        chk_rd(pllsd_pkg::ADDR_MAIN, 32'(pllsd_pkg::MAIN_RST));
        chk_rd(8'h18, ZERO);
        chk(32'(loop_control_out), ZERO);
        $display("Test reset done");
        // Main words: boundaries, then random ones, early and late strobe
        r = pllsd_pkg::REF_RST;
        for (int i = 0; i < 6; i++) begin
            a = i == 0 ? 7'h00 : i == 1 ? 7'h7F : 7'($urandom_range(127));
            n = i == 0 ? 11'h005 : i == 1 ? 11'h7FF
                : 11'($urandom_range(2047, 127));
            x = i % 2 * 200;
            pllsd_host_inst.send(main_word(a, n), 19, x);
            chk_rd(pllsd_pkg::ADDR_SWALLOW, 32'(a));
            chk_rd(pllsd_pkg::ADDR_MAIN, 32'(n));
            chk_rd(pllsd_pkg::ADDR_REF, 32'(r));
        end
        $display("Test main word done");
        // Reference words; one frame has stray leading bits
        for (int i = 0; i < 4; i++) begin
            r = i == 0 ? 14'h0008 : i == 1 ? 14'h3FFF
                : 14'($urandom_range(16383, 8));
            x = i == 2 ? 19 : 15;
            d = $urandom;
            pllsd_host_inst.send(ref_word(d[3:0], r), x, 0);
            chk_rd(pllsd_pkg::ADDR_REF, 32'(r));
            chk_rd(pllsd_pkg::ADDR_MAIN, 32'(n));
        end
        $display("Test reference word done");
        // Sticky events, mask and read-clear
        chk_rd(pllsd_pkg::ADDR_STATUS, 32'h0000_0003);
        chk_rd(pllsd_pkg::ADDR_STATUS, ZERO);
        reg_wr(pllsd_pkg::ADDR_MASK, ONE);
        chk_rd(pllsd_pkg::ADDR_MASK, ONE);
        pllsd_host_inst.send(ref_word(4'h0, 14'h0008), 15, 0);
        chk(32'(irq), ZERO);
        pllsd_host_inst.send(main_word(7'h02, 11'h005), 19, 0);
        chk(32'(irq), ONE);
        chk_rd(pllsd_pkg::ADDR_STATUS, 32'h0000_0003);
        repeat (2) @(posedge clk);
        #1;
        chk(32'(irq), ZERO);
        $display("Test interrupt done");
        // Frozen enable misses a whole frame and its load
        @(posedge clk);
        en <= 1'b0;
        pllsd_host_inst.send(main_word(7'h11, 11'h123), 19, 0);
        @(posedge clk);
        en <= 1'b1;
        chk_rd(pllsd_pkg::ADDR_MAIN, 32'h0000_0005);
        chk_rd(pllsd_pkg::ADDR_SWALLOW, 32'h0000_0002);
        $display("Test enable done");
        // Wake with A 2, N 5, R 8; vco edge every 10 cycles
        reg_wr(pllsd_pkg::ADDR_MASK, 32'h0000_0008);
        wake(t1, tr, tl, per, ml, lk);
        chk(32'(t1 >= 0 && t1 < tr), ONE);
        chk(32'(tl), 32'(tr));
        chk(32'(per), 32'(5 * 10));
        // A vco periods, less the cycle that registers the main pulse
        chk(32'(ml), 32'(2 * 10 - 1));
        chk(32'(lk), ONE);
        chk(32'(irq), ONE);
        reg_rd(pllsd_pkg::ADDR_STATE, d);
        chk(32'(d[2:0]), 32'h0000_0006);
        reg_rd(pllsd_pkg::ADDR_STATUS, d);
        chk(d, 32'h0000_000C);
        $display("Test wake done");
        // Power-down stops and clears; a second wake repeats the first
        @(posedge clk);
        power_select <= 1'b0;
        repeat (8) @(posedge clk);
        x = 0;
        repeat (300) begin
            @(posedge clk);
            #1;
            if (divided_vco !== 1'b0 || divided_reference !== 1'b0
                || loop_control_out !== 1'b0) x++;
        end
        chk(32'(x), ZERO);
        reg_rd(pllsd_pkg::ADDR_STATE, d);
        chk(32'(d[1:0]), 32'(pllsd_pkg::PWR_DOWN));
        wake(t1b, tr, tl, per, ml, lk);
        chk(32'(t1b), 32'(t1));
        $display("Test power-down done");
        finish_test();
    end

    // Cut a hang short well past the expected run of about 37 us
    initial begin
        #200000;
        num_errors++;
        finish_test();
    end
endmodule
